/* core/sbl_pkg.sv */
// Constants, timing and state types shared by both ends of the serial byte link
// Overview of operation
// - Two one-way lines, one per end.
// - Data frame: start, one, eight data, stop.
// - Acknowledge frame: start bit then a zero.
// - No new byte until previous acknowledged.
// - Messages travel as separately acknowledged bytes.
// - One byte holding buffer, nothing lost.
// - Acknowledge means accepted and room for more.
// - Message done only after last acknowledge.
// - Line interleaves data and acknowledges, arbitrated.
// - Acknowledge may go once reception starts.
// - Early acknowledge allows gapless next byte.
// - Link runs at ten megabits per second.
// - Receiver needs no phase lock to sender.
package sbl_pkg;

   // Clock and bit rate; their ratio is 5:2 so a fractional divider is used
   localparam int CLK_HZ = 25_000_000;
   localparam int BIT_HZ = 10_000_000;
   localparam int RATE_GCD = 5_000_000;
   localparam logic [2:0] ACC_MOD = 3'(CLK_HZ / RATE_GCD);
   localparam logic [2:0] ACC_STEP = 3'(BIT_HZ / RATE_GCD);
   // Phase preset on a start edge: the first strobe falls one clock into the start bit,
   // so later strobes stay inside 2 or 3 clock bits; a lower preset lands on bit edges
   localparam logic [2:0] ACC_START = 3'h3;
   localparam logic [2:0] ACC_RST = 3'h0;

   // Frame layout
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] DATA_FRAME_LEN = 4'hB;
   localparam logic [3:0] ACK_FRAME_LEN = 4'h2;
   localparam logic [1:0] ACK_FRAME = 2'h1;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // Receive buffer depth
   localparam int FIFO_DEPTH = 16;

   // Receiver states, Gray along start, type, body, stop
   typedef enum logic [2:0] {
      SBL_RX_IDLE = 3'b000,
      SBL_RX_START = 3'b001,
      SBL_RX_TYPE = 3'b011,
      SBL_RX_BODY = 3'b010,
      SBL_RX_STOP = 3'b110
   } sbl_rx_state_t;

endpackage

/* core/sbl_if.sv */
// Two one-way serial lines joining end A and end B
interface sbl_if;
   logic a_to_b;
   logic b_to_a;
   modport end_a (output a_to_b, input b_to_a);
   modport end_b (output b_to_a, input a_to_b);
endinterface

/* core/sbl_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
module sbl_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Fill side
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side
   output logic o_out_valid,
   output logic [W-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] DEPTH_N = (AW+1)'(D);
   localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;

   // Honest flags from the occupancy count
   assign o_in_ready = (cnt_q != DEPTH_N);
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data = mem[rd_q];

   // Storage has no reset; only pointers matter
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_q] <= i_in_data;
      end
   end

   // Pointers wrap explicitly so any depth works
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // sbl_fifo

/* core/sbl_end_a.sv */
// Link engine and end A of the serial byte link
module sbl_node (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Serial lines
   input wire logic i_line,
   output logic o_line,
   // Transmit request
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_last,
   output logic o_tx_ready,
   output logic o_tx_done,
   // Receive stream
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready
);
   // ---------------- Transmit bit clock ----------------
   logic [2:0] tacc_q;
   wire [3:0] tacc_sum = {1'b0, tacc_q} + {1'b0, sbl_pkg::ACC_STEP};
   wire tick = (tacc_sum >= {1'b0, sbl_pkg::ACC_MOD});
   wire [2:0] tacc_d = tick ? 3'(tacc_sum - {1'b0, sbl_pkg::ACC_MOD}) : tacc_sum[2:0];

   // ten megabit rate
   // Average 2 ticks per 5 clocks; bits last 2 or 3 clocks each
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tacc_q <= sbl_pkg::ACC_RST;
      end else begin
         tacc_q <= tacc_d;
      end
   end

   // ---------------- Receive side ----------------
   logic s1_q;
   logic s2_q;
   logic s3_q;
   sbl_pkg::sbl_rx_state_t rst_q;
   logic [2:0] racc_q;
   logic [3:0] rbit_q;
   logic [7:0] rbyte_q;
   logic hold_v_q;
   logic ack_owed_q;
   logic fifo_in_ready;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= i_line;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   wire start_edge = s2_q && !s3_q && (rst_q == sbl_pkg::SBL_RX_IDLE);
   wire [3:0] racc_sum = {1'b0, racc_q} + {1'b0, sbl_pkg::ACC_STEP};
   wire samp = (rst_q != sbl_pkg::SBL_RX_IDLE) && (racc_sum >= {1'b0, sbl_pkg::ACC_MOD});
   wire [2:0] racc_d = samp ? 3'(racc_sum - {1'b0, sbl_pkg::ACC_MOD}) : racc_sum[2:0];
   wire ack_rcvd = samp && (rst_q == sbl_pkg::SBL_RX_TYPE) && !s2_q;
   wire data_begun = samp && (rst_q == sbl_pkg::SBL_RX_TYPE) && s2_q;
   wire body_last = (rbit_q == 4'(sbl_pkg::BYTE_BITS - 1));
   wire byte_done = samp && (rst_q == sbl_pkg::SBL_RX_STOP);

   // Phase accumulator restarts on each start edge
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         racc_q <= sbl_pkg::ACC_RST;
      end else if (start_edge) begin
         racc_q <= sbl_pkg::ACC_START;
      end else begin
         racc_q <= racc_d;
      end
   end

   // frame walk
   // Stop bit level is not checked; a bad stop still delivers the byte
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_q <= sbl_pkg::SBL_RX_IDLE;
         rbit_q <= sbl_pkg::BIT_CNT_RST;
      end else begin
         unique case (rst_q)
            sbl_pkg::SBL_RX_IDLE: begin
               if (start_edge) begin
                  rst_q <= sbl_pkg::SBL_RX_START;
               end
            end
            sbl_pkg::SBL_RX_START: begin
               if (samp) begin
                  rst_q <= sbl_pkg::SBL_RX_TYPE;
               end
            end
            sbl_pkg::SBL_RX_TYPE: begin
               if (samp) begin
                  rst_q <= s2_q ? sbl_pkg::SBL_RX_BODY : sbl_pkg::SBL_RX_IDLE;
                  rbit_q <= sbl_pkg::BIT_CNT_RST;
               end
            end
            sbl_pkg::SBL_RX_BODY: begin
               if (samp) begin
                  rbit_q <= rbit_q + 4'h1;
                  if (body_last) begin
                     rst_q <= sbl_pkg::SBL_RX_STOP;
                  end
               end
            end
            sbl_pkg::SBL_RX_STOP: begin
               if (samp) begin
                  rst_q <= sbl_pkg::SBL_RX_IDLE;
               end
            end
            default: begin
               rst_q <= sbl_pkg::SBL_RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rbyte_q <= sbl_pkg::BYTE_RST;
      end else if (samp && rst_q == sbl_pkg::SBL_RX_BODY) begin
         rbyte_q <= {s2_q, rbyte_q[7:1]};
      end
   end

   // single holding byte
   // Drained into the FIFO; the ack policy keeps it from being overrun
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hold_v_q <= 1'b0;
      end else if (byte_done) begin
         hold_v_q <= 1'b1;
      end else if (fifo_in_ready) begin
         hold_v_q <= 1'b0;
      end
   end

   sbl_fifo #(
      .W(8),
      .D(sbl_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(hold_v_q),
      .i_in_data(rbyte_q),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(o_rx_valid),
      .o_out_data(o_rx_data),
      .i_out_ready(i_rx_ready)
   );

   // ---------------- Transmit side ----------------
   logic [9:0] sr_q;
   logic [3:0] left_q;
   logic line_q;
   logic outst_q;
   logic last_q;
   logic ack_load;

   wire ack_ready = ack_owed_q && fifo_in_ready && !hold_v_q;
   wire frame_free = tick && (left_q == sbl_pkg::BIT_CNT_RST);
   assign ack_load = frame_free && ack_ready;
   wire data_load = frame_free && !ack_ready && !outst_q && i_tx_valid;
   assign o_tx_ready = data_load;
   assign o_line = line_q;

   // Owed flag; a new data start outranks a same-cycle clear
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_owed_q <= 1'b0;
      end else if (data_begun) begin
         ack_owed_q <= 1'b1;
      end else if (ack_load) begin
         ack_owed_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sr_q <= '0;
         left_q <= sbl_pkg::BIT_CNT_RST;
         line_q <= 1'b0;
      end else if (ack_load) begin
         line_q <= sbl_pkg::ACK_FRAME[0];
         sr_q <= {9'h000, sbl_pkg::ACK_FRAME[1]};
         left_q <= sbl_pkg::ACK_FRAME_LEN - 4'h1;
      end else if (data_load) begin
         line_q <= 1'b1;
         sr_q <= {1'b0, i_tx_data, 1'b1};
         left_q <= sbl_pkg::DATA_FRAME_LEN - 4'h1;
      end else if (tick) begin
         line_q <= (left_q != sbl_pkg::BIT_CNT_RST) && sr_q[0];
         sr_q <= {1'b0, sr_q[9:1]};
         if (left_q != sbl_pkg::BIT_CNT_RST) begin
            left_q <= left_q - 4'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         outst_q <= 1'b0;
         last_q <= 1'b0;
         o_tx_done <= 1'b0;
      end else begin
         o_tx_done <= ack_rcvd && outst_q && last_q;
         if (data_load) begin
            outst_q <= 1'b1;
            last_q <= i_tx_last;
         end else if (ack_rcvd) begin
            outst_q <= 1'b0;
         end
      end
   end
endmodule // sbl_node

// End A: drives the A-to-B line
module sbl_end_a (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   sbl_if.end_a link,
   // Transmit request
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_last,
   output logic o_tx_ready,
   output logic o_tx_done,
   // Receive stream
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready
);
   sbl_node u_node (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_line(link.b_to_a),
      .o_line(link.a_to_b),
      .i_tx_valid(i_tx_valid),
      .i_tx_data(i_tx_data),
      .i_tx_last(i_tx_last),
      .o_tx_ready(o_tx_ready),
      .o_tx_done(o_tx_done),
      .o_rx_valid(o_rx_valid),
      .o_rx_data(o_rx_data),
      .i_rx_ready(i_rx_ready)
   );
endmodule // sbl_end_a

/* core/sbl_end_b.sv */
// End B of the serial byte link: same engine, opposite line roles
module sbl_end_b (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Link lines
   sbl_if.end_b link,
   // Transmit request
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_last,
   output logic o_tx_ready,
   output logic o_tx_done,
   // Receive stream
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready
);
   sbl_node u_node (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_line(link.a_to_b),
      .o_line(link.b_to_a),
      .i_tx_valid(i_tx_valid),
      .i_tx_data(i_tx_data),
      .i_tx_last(i_tx_last),
      .o_tx_ready(o_tx_ready),
      .o_tx_done(o_tx_done),
      .o_rx_valid(o_rx_valid),
      .o_rx_data(o_rx_data),
      .i_rx_ready(i_rx_ready)
   );
endmodule // sbl_end_b

/* tb/sbl_link_sva.sv */
// Concurrent checks on the two serial lines of the byte link
module sbl_link_sva (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Serial lines
   input wire logic a_to_b,
   input wire logic b_to_a
);
   // Longest high run: start, type one and eight ones, three clocks each
   localparam logic [5:0] HI_MAX = 6'h1E;
   logic [5:0] hi_a_q;
   logic [5:0] hi_b_q;
   logic [5:0] hi_a_d;
   logic [5:0] hi_b_d;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   // High run lengths; wrap only long after the bound has fired
   assign hi_a_d = a_to_b ? hi_a_q + 6'h01 : 6'h00;
   assign hi_b_d = b_to_a ? hi_b_q + 6'h01 : 6'h00;

   // Run counters
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hi_a_q <= 6'h00;
         hi_b_q <= 6'h00;
      end else begin
         hi_a_q <= hi_a_d;
         hi_b_q <= hi_b_d;
      end
   end

   // A level change marks a bit tick, and a rise opens a frame
   sequence s_tick_a;
      $changed(a_to_b);
   endsequence
   sequence s_tick_b;
      $changed(b_to_a);
   endsequence
   sequence s_start_a;
      !a_to_b ##1 a_to_b;
   endsequence
   sequence s_start_b;
      !b_to_a ##1 b_to_a;
   endsequence

   chk_bit_hold_a: assert property (s_tick_a |=> $stable(a_to_b))
      else $error("A line bit too short");
   chk_bit_hold_b: assert property (s_tick_b |=> $stable(b_to_a))
      else $error("B line bit too short");
   chk_frame_end_a: assert property (s_start_a |-> ##[2:30] !a_to_b)
      else $error("A line frame never returns low");
   chk_frame_end_b: assert property (s_start_b |-> ##[2:30] !b_to_a)
      else $error("B line frame never returns low");
   chk_high_run_a: assert property (hi_a_q <= HI_MAX)
      else $error("A line high too long");
   chk_high_run_b: assert property (hi_b_q <= HI_MAX)
      else $error("B line high too long");
   chk_reset_idle_a: assert property ($rose(i_arst_n) |-> !a_to_b)
      else $error("A line not idle after reset");
   chk_reset_idle_b: assert property ($rose(i_arst_n) |-> !b_to_a)
      else $error("B line not idle after reset");
endmodule // sbl_link_sva

/* tb/test_serial_byte_link_interface.sv */
// Self-checking bench with both link ends joined by one interface
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
$display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module test_serial_byte_link_interface;
   timeunit 1ns;
   timeprecision 1ns;
   // Index 0 is end A, index 1 is end B
   logic i_clk;
   logic i_arst_n;
   logic [1:0] tx_valid;
   logic [1:0] tx_last;
   logic [1:0] rx_ready;
   logic [1:0][7:0] tx_data;
   wire [1:0] tx_ready;
   wire [1:0] tx_done;
   wire [1:0] rx_valid;
   wire [7:0] rx_data [2];
   wire [1:0] lines;
   int mismatches;
   int n_tests;
   int done_cnt [2];
   int taken [2];
   logic [7:0] got [2][$];
   logic [7:0] msg [$];

   sbl_if link_if ();
   sbl_end_a sbl_end_a_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .link(link_if.end_a),
      .i_tx_valid(tx_valid[0]), .i_tx_data(tx_data[0]), .i_tx_last(tx_last[0]),
      .o_tx_ready(tx_ready[0]), .o_tx_done(tx_done[0]), .o_rx_valid(rx_valid[0]),
      .o_rx_data(rx_data[0]), .i_rx_ready(rx_ready[0]));
   sbl_end_b sbl_end_b_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .link(link_if.end_b),
      .i_tx_valid(tx_valid[1]), .i_tx_data(tx_data[1]), .i_tx_last(tx_last[1]),
      .o_tx_ready(tx_ready[1]), .o_tx_done(tx_done[1]), .o_rx_valid(rx_valid[1]),
      .o_rx_data(rx_data[1]), .i_rx_ready(rx_ready[1]));
   sbl_link_sva sbl_link_sva_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .a_to_b(link_if.a_to_b), .b_to_a(link_if.b_to_a));
   assign lines = {link_if.b_to_a, link_if.a_to_b};

   // 25 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // Record pops, takes and done pulses at each edge
   always @(posedge i_clk) begin
      for (int e = 0; e < 2; e++) begin
         if (rx_valid[e] && rx_ready[e]) got[e].push_back(rx_data[e]);
         if (tx_done[e]) done_cnt[e]++;
         if (tx_valid[e] && tx_ready[e]) taken[e]++;
      end
   end

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic fail_timeout();
      mismatches++;
      end_sim();
   endtask

   // Reset is held eight cycles; also serves as the mid-run reset
   task automatic do_reset();
      i_arst_n <= 1'b0;
      tx_valid <= 2'h0;
      rx_ready <= 2'h3;
      repeat (8) @(posedge i_clk);
      for (int e = 0; e < 2; e++) begin
         got[e].delete();
         done_cnt[e] = 0;
         taken[e] = 0;
      end
      i_arst_n <= 1'b1;
   endtask

   // Offer one byte and hold it until the edge that takes it
   task automatic send(input int e, input logic [7:0] b, input logic last);
      tx_valid[e] <= 1'b1;
      tx_data[e] <= b;
      tx_last[e] <= last;
      for (int i = 0; i <= 4000; i++) begin
         @(negedge i_clk);
         if (tx_ready[e] === 1'b1) break;
         if (i == 4000) fail_timeout();
      end
      @(posedge i_clk);
   endtask

   // Valid drops only after the whole message, so bytes go back to back
   task automatic send_msg(input int e, input logic [7:0] m [$]);
      foreach (m[i]) send(e, m[i], 1'(i == m.size() - 1));
      tx_valid[e] <= 1'b0;
   endtask

   // Wait for a message at end e, then judge bytes and the sender's done
   task automatic check_rx(input int e, input logic [7:0] m [$]);
      for (int i = 0; got[e].size() < m.size() || done_cnt[1 - e] < 1; i++) begin
         if (i == 3000) fail_timeout();
         @(posedge i_clk);
      end
      repeat (60) @(posedge i_clk);
      // Judge away from the edge so the recorder has settled
      @(negedge i_clk);
      `CHK(got[e].size(), m.size())
      foreach (m[i]) `CHK(got[e][i], m[i])
      `CHK(done_cnt[1 - e], 1)
   endtask

   // Sample mid-bit; bit edges stray at most 20 ns from the 100 ns grid
   task automatic grab(input int sel, input int nbits, input int steps,
      output logic [10:0] f);
      f = 11'h000;
      for (int i = 0; lines[sel] !== 1'b1; i++) begin
         if (i == steps) fail_timeout();
         #10;
      end
      #45;
      for (int k = 0; k < nbits; k++) begin
         f[k] = lines[sel];
         if (k < nbits - 1) #100;
      end
   endtask

   // A to B message with edge-case bytes, framing watched on both lines
   task automatic test_msg();
      logic [10:0] f;
      msg = '{8'h00, 8'hFF, 8'hA5};
      do_reset();
      fork
         begin
            send_msg(0, msg);
            `CHK(done_cnt[0], 0)
         end
         for (int k = 0; k < 3; k++) begin
            grab(0, 11, (k == 0) ? 400 : 10, f);
            `CHK(f, {1'b0, msg[k], 2'b11})
         end
         for (int k = 0; k < 3; k++) begin
            grab(1, 2, 1000, f);
            `CHK(f[1:0], 2'b01)
         end
      join
      check_rx(1, msg);
      $display("test_msg finished");
   endtask

   // Both ends send at once: each line mixes data with acks
   task automatic test_both();
      logic [7:0] mb [$];
      msg = '{8'h3C, 8'h01, 8'h80, 8'h5A};
      mb = '{8'hC3, 8'hFE, 8'h7F};
      do_reset();
      fork
         send_msg(0, msg);
         send_msg(1, mb);
         check_rx(1, msg);
         check_rx(0, mb);
      join
      $display("test_both finished");
   endtask

   // Stalled consumer: FIFO and holding byte fill, then acks stop
   task automatic test_stall();
      msg.delete();
      for (int i = 0; i < 18; i++) msg.push_back(8'(8'h11 * i));
      do_reset();
      rx_ready[1] <= 1'b0;
      fork
         send_msg(0, msg);
         begin
            repeat (1500) @(negedge i_clk);
            `CHK(taken[0], 17)
            `CHK(rx_valid[1], 1'b1)
            @(posedge i_clk);
            rx_ready[1] <= 1'b1;
            check_rx(1, msg);
         end
      join
      @(negedge i_clk);
      `CHK(rx_valid[1], 1'b0)
      $display("test_stall finished");
   endtask

   // Main sequence
   initial begin
      tx_last <= 2'h0;
      tx_data <= 16'h0000;
      mismatches = 0;
      n_tests = 0;
      test_msg();
      test_both();
      test_stall();
      end_sim();
   end
endmodule // test_serial_byte_link_interface
